// ### logic/i2cer_map.vh
// Notes on behaviour
// - status reads 0xf8 while interrupt flag clear
// - start or stop inside frame is bus error
// - bus error counts only while taking part
// - bus error: unaddressed slave, release, flag, 0x00
// - error state: stop bit recovers without stop
// - undefined internal state also gives code 0x00
// - foreign repeated start first: release, no interrupt flag
// - after foreign stop send start, code 0x08
// - lost arbitration reported by dedicated code
// - start bit after loss: start when free
// - stop with start pending forces bus access
// - hardware clears stop bit after forced access
// - low data on free bus: extra clocks
// - retry start after every two extra clocks
// - data released: normal start, code 0x08
// - forced access, repeated start recover likewise
`ifndef I2CER_MAP_VH
`define I2CER_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define I2CER_OFS_CTL_SET 8'h00
`define I2CER_OFS_STATUS 8'h04
`define I2CER_OFS_DATA 8'h08
`define I2CER_OFS_CTL_CLR 8'h18
`define I2CER_OFS_EVT_STAT 8'h20
`define I2CER_OFS_EVT_CLR 8'h24
`define I2CER_OFS_EVT_EN 8'h28

// ----------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------
`define I2CER_BIT_ACK 2
`define I2CER_BIT_SI 3
`define I2CER_BIT_STOP 4
`define I2CER_BIT_START 5
`define I2CER_BIT_EN 6

// ----------------------------------------------------------------
// event register bit positions
// ----------------------------------------------------------------
`define I2CER_EV_SI 0
`define I2CER_EV_BUSERR 1
`define I2CER_EV_ARBLOST 2
`define I2CER_EV_RSLOST 3
`define I2CER_EV_W 4

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define I2CER_ST_NOINFO 8'hf8
`define I2CER_ST_BUSERR 8'h00
`define I2CER_ST_START 8'h08
`define I2CER_ST_RSTART 8'h10
`define I2CER_ST_AW_ACK 8'h18
`define I2CER_ST_AW_NAK 8'h20
`define I2CER_ST_D_ACK 8'h28
`define I2CER_ST_D_NAK 8'h30
`define I2CER_ST_ARB_MT 8'h38
`define I2CER_ST_ARB_SW 8'h68
`define I2CER_ST_ARB_GC 8'h78

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define I2CER_RST_DATA 8'h00
`define I2CER_RST_EVT_EN 4'h0
`define I2CER_CLK_NS 50
`define I2CER_QTR_NS 2500
`define I2CER_QTR_CYC (`I2CER_QTR_NS / `I2CER_CLK_NS)

`endif

// ### logic/i2cer_sync.v
`timescale 1ns/100ps
`include "i2cer_map.vh"

// two-stage synchroniser, one lane per bit
module i2cer_sync #(
	parameter W = 2
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// asynchronous in, synchronous out
	input wire [W-1:0] d,
	output wire [W-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_lane
			reg meta_r;
			reg sync_r;
			// idle bus level is high, so reset to one
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
				end else begin
					meta_r <= d[i];
					sync_r <= meta_r;
				end
			end
			assign q[i] = sync_r;
		end
	endgenerate

endmodule // i2cer_sync

// ### logic/i2cer_tick.v
`timescale 1ns/100ps
`include "i2cer_map.vh"

// quarter-bit enable pulse; restarts whenever run drops
module i2cer_tick #(
	parameter DIV = `I2CER_QTR_CYC
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// control and pulse
	input wire run,
	output reg tick
);

	reg [15:0] cnt_r;

	// phase restarts at each new bus action
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_r == DIV[15:0] - 16'h0001) begin
			cnt_r <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick <= 1'b0;
		end
	end

endmodule // i2cer_tick

// ### logic/i2cer_core.v
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "i2cer_map.vh"

// byte controller master engine with bus error handling and recovery
module i2cer_core #(
	parameter QTR_CYC = `I2CER_QTR_CYC
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// interrupt
	output reg irq,
	// i2c pins, open drain
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe_n,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_n
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam ST_IDLE = 9'h001;
	localparam ST_WAIT = 9'h002;
	localparam ST_START = 9'h004;
	localparam ST_UNST = 9'h008;
	localparam ST_HOLD = 9'h010;
	localparam ST_BYTE = 9'h020;
	localparam ST_STOP = 9'h040;
	localparam ST_RSTA = 9'h080;
	localparam ST_ERR = 9'h100;

	reg [8:0] state_r;
	reg [1:0] q_r;
	reg [3:0] bit_r;
	reg [7:0] code_r;
	reg [7:0] data_r;
	reg ctl_ack_r;
	reg ctl_si_r;
	reg ctl_stop_r;
	reg ctl_start_r;
	reg ctl_en_r;
	reg addr_ph_r;
	reg scl_drv_r;
	reg sda_drv_r;
	reg busy_r;
	reg [`I2CER_EV_W-1:0] ev_pulse_r;
	reg [`I2CER_EV_W-1:0] evt_r;
	reg [`I2CER_EV_W-1:0] ien_r;
	reg wr_pend_r;
	reg [7:0] waddr_r;
	reg scl_p_r;
	reg sda_p_r;

	wire [1:0] pin_s;
	wire scl_s;
	wire sda_s;
	wire tick;
	wire run;
	wire st_det;
	wire sp_det;
	wire addr_ph;
	wire wr_set;
	wire wr_clr;
	wire wr_dat;
	wire wr_evclr;
	wire wr_even;
	wire [7:0] wbyte;

	// ----------------------------------------------------------------
	// pin sampling and bus conditions
	// ----------------------------------------------------------------
	i2cer_sync #(
		.W(2)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({scl_i, sda_i}),
		.q(pin_s)
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	// previous synchronised levels for edge finding
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end else begin
			scl_p_r <= scl_s;
			sda_p_r <= sda_s;
		end
	end

	// start: data falls with clock high; stop: data rises
	assign st_det = scl_s && scl_p_r && sda_p_r && !sda_s;
	assign sp_det = scl_s && scl_p_r && !sda_p_r && sda_s;

	// quarter-bit pacing only in the start, unstick, byte, stop and repeated-start states
	assign run = (state_r == ST_START) || (state_r == ST_UNST) || (state_r == ST_BYTE) ||
		(state_r == ST_STOP) || (state_r == ST_RSTA);

	i2cer_tick #(
		.DIV(QTR_CYC)
	) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(run),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ph = hsel && htrans[1] && hready;
	assign wbyte = hwdata[7:0];

	// one decode shared by write strobes
	function is_wr;
		input pend;
		input [7:0] a;
		input [7:0] ofs;
		begin
			is_wr = pend && (a == ofs);
		end
	endfunction

	assign wr_set = is_wr(wr_pend_r, waddr_r, `I2CER_OFS_CTL_SET);
	assign wr_clr = is_wr(wr_pend_r, waddr_r, `I2CER_OFS_CTL_CLR);
	assign wr_dat = is_wr(wr_pend_r, waddr_r, `I2CER_OFS_DATA);
	assign wr_evclr = is_wr(wr_pend_r, waddr_r, `I2CER_OFS_EVT_CLR);
	assign wr_even = is_wr(wr_pend_r, waddr_r, `I2CER_OFS_EVT_EN);

	// write address held for the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			waddr_r <= 8'h00;
		end else if (hready) begin
			wr_pend_r <= addr_ph && hwrite;
			waddr_r <= haddr[7:0];
		end
	end

	// read data taken at the address phase; unmapped reads zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_ph && !hwrite) begin
			case (haddr[7:0])
				`I2CER_OFS_CTL_SET: hrdata <= {25'h0000000, ctl_en_r, ctl_start_r, ctl_stop_r,
					ctl_si_r, ctl_ack_r, 2'b00};
				`I2CER_OFS_STATUS: hrdata <= {24'h000000, ctl_si_r ? code_r : `I2CER_ST_NOINFO};
				`I2CER_OFS_DATA: hrdata <= {24'h000000, data_r};
				`I2CER_OFS_EVT_STAT: hrdata <= {28'h0000000, evt_r};
				`I2CER_OFS_EVT_EN: hrdata <= {28'h0000000, ien_r};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	// a new event beats a clear in the same cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_r <= 4'h0;
			ien_r <= `I2CER_RST_EVT_EN;
			irq <= 1'b0;
		end else begin
			evt_r <= (evt_r & ~(wr_evclr ? wbyte[3:0] : 4'h0)) | ev_pulse_r;
			if (wr_even) begin
				ien_r <= wbyte[3:0];
			end
			irq <= |(evt_r & ien_r);
		end
	end

	// ----------------------------------------------------------------
	// engine and control bits
	// ----------------------------------------------------------------
	// software writes first; engine assignments below take priority
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			q_r <= 2'b00;
			bit_r <= 4'h0;
			code_r <= `I2CER_ST_NOINFO;
			data_r <= `I2CER_RST_DATA;
			ctl_ack_r <= 1'b0;
			ctl_si_r <= 1'b0;
			ctl_stop_r <= 1'b0;
			ctl_start_r <= 1'b0;
			ctl_en_r <= 1'b0;
			addr_ph_r <= 1'b0;
			scl_drv_r <= 1'b0;
			sda_drv_r <= 1'b0;
			busy_r <= 1'b0;
			ev_pulse_r <= 4'h0;
		end else begin
			ev_pulse_r <= 4'h0;
			if (wr_set) begin
				ctl_ack_r <= ctl_ack_r | wbyte[`I2CER_BIT_ACK];
				ctl_si_r <= ctl_si_r | wbyte[`I2CER_BIT_SI];
				ctl_stop_r <= ctl_stop_r | wbyte[`I2CER_BIT_STOP];
				ctl_start_r <= ctl_start_r | wbyte[`I2CER_BIT_START];
				ctl_en_r <= ctl_en_r | wbyte[`I2CER_BIT_EN];
			end
			// stop bit has no clear; only hardware drops it
			if (wr_clr) begin
				ctl_ack_r <= ctl_ack_r & ~wbyte[`I2CER_BIT_ACK];
				ctl_si_r <= ctl_si_r & ~wbyte[`I2CER_BIT_SI];
				ctl_start_r <= ctl_start_r & ~wbyte[`I2CER_BIT_START];
				ctl_en_r <= ctl_en_r & ~wbyte[`I2CER_BIT_EN];
			end
			if (wr_dat) begin
				data_r <= wbyte;
			end
			// bus ownership follows conditions seen on the wires
			if (sp_det) begin
				busy_r <= 1'b0;
			end else if (st_det) begin
				busy_r <= 1'b1;
			end

			if (!ctl_en_r) begin
				state_r <= ST_IDLE;
				scl_drv_r <= 1'b0;
				sda_drv_r <= 1'b0;
			end else if ((state_r == ST_BYTE) && (st_det || sp_det)) begin
				// only a frame we take part in is aborted
				state_r <= ST_ERR;
				scl_drv_r <= 1'b0;
				sda_drv_r <= 1'b0;
				code_r <= `I2CER_ST_BUSERR;
				ctl_si_r <= 1'b1;
				ev_pulse_r[`I2CER_EV_BUSERR] <= 1'b1;
				ev_pulse_r[`I2CER_EV_SI] <= 1'b1;
			end else begin
				case (state_r)
					ST_IDLE: begin
						// unaddressed slave, bus released
						scl_drv_r <= 1'b0;
						sda_drv_r <= 1'b0;
						if (ctl_stop_r && !ctl_start_r && !ctl_si_r) begin
							ctl_stop_r <= 1'b0;
						end else if (ctl_start_r && !ctl_si_r) begin
							state_r <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (ctl_start_r && ctl_stop_r) begin
							// forced access: act as if stop was seen, drive none
							ctl_stop_r <= 1'b0;
							busy_r <= 1'b0;
							q_r <= 2'b00;
							state_r <= ST_START;
						end else if (!busy_r) begin
							q_r <= 2'b00;
							state_r <= ST_START;
						end
					end
					ST_START: begin
						if (tick) begin
							case (q_r)
								2'b00: begin
									// a held clock stalls here; only its holder can free it
									if (scl_s && !sda_s) begin
										bit_r <= 4'h0;
										state_r <= ST_UNST;
									end else if (scl_s) begin
										sda_drv_r <= 1'b1;
										q_r <= 2'b01;
									end
								end
								2'b01: begin
									q_r <= 2'b10;
								end
								default: begin
									scl_drv_r <= 1'b1;
									code_r <= `I2CER_ST_START;
									ctl_si_r <= 1'b1;
									addr_ph_r <= 1'b1;
									ev_pulse_r[`I2CER_EV_SI] <= 1'b1;
									state_r <= ST_HOLD;
								end
							endcase
						end
					end
					ST_UNST: begin
						// low for two quarters, high for two, twice over
						if (tick) begin
							q_r <= q_r + 2'b01;
							if (q_r == 2'b00) begin
								scl_drv_r <= 1'b1;
							end else if (q_r == 2'b10) begin
								scl_drv_r <= 1'b0;
							end else if (q_r == 2'b11) begin
								bit_r <= bit_r + 4'h1;
								if (bit_r == 4'h1) begin
									state_r <= ST_START;
								end
							end
						end
					end
					ST_HOLD: begin
						// clock held low until the flag is cleared
						scl_drv_r <= 1'b1;
						q_r <= 2'b00;
						bit_r <= 4'h0;
						if (!ctl_si_r) begin
							if (ctl_stop_r) begin
								state_r <= ST_STOP;
							end else if (ctl_start_r) begin
								state_r <= ST_RSTA;
							end else begin
								state_r <= ST_BYTE;
							end
						end
					end
					ST_BYTE: begin
						if (tick) begin
							case (q_r)
								2'b00: begin
									sda_drv_r <= (bit_r != 4'h8) && !data_r[7];
									q_r <= 2'b01;
								end
								2'b01: begin
									scl_drv_r <= 1'b0;
									q_r <= 2'b10;
								end
								2'b10: begin
									// stretched clock holds the sample point
									if (scl_s && (bit_r != 4'h8) && !sda_drv_r && !sda_s) begin
										scl_drv_r <= 1'b0;
										sda_drv_r <= 1'b0;
										code_r <= `I2CER_ST_ARB_MT;
										ctl_si_r <= 1'b1;
										ev_pulse_r[`I2CER_EV_ARBLOST] <= 1'b1;
										ev_pulse_r[`I2CER_EV_SI] <= 1'b1;
										state_r <= ST_IDLE;
									end else if (scl_s) begin
										if (bit_r != 4'h8) begin
											data_r <= {data_r[6:0], sda_s};
										end
										q_r <= 2'b11;
									end
								end
								default: begin
									scl_drv_r <= 1'b1;
									q_r <= 2'b00;
									if (bit_r == 4'h8) begin
										sda_drv_r <= 1'b0;
										addr_ph_r <= 1'b0;
										if (addr_ph_r) begin
											code_r <= sda_s ? `I2CER_ST_AW_NAK : `I2CER_ST_AW_ACK;
										end else begin
											code_r <= sda_s ? `I2CER_ST_D_NAK : `I2CER_ST_D_ACK;
										end
										ctl_si_r <= 1'b1;
										ev_pulse_r[`I2CER_EV_SI] <= 1'b1;
										state_r <= ST_HOLD;
									end else begin
										bit_r <= bit_r + 4'h1;
									end
								end
							endcase
						end
					end
					ST_STOP: begin
						if (tick) begin
							case (q_r)
								2'b00: begin
									sda_drv_r <= 1'b1;
									q_r <= 2'b01;
								end
								2'b01: begin
									scl_drv_r <= 1'b0;
									q_r <= 2'b10;
								end
								default: begin
									if (scl_s) begin
										sda_drv_r <= 1'b0;
										ctl_stop_r <= 1'b0;
										state_r <= ST_IDLE;
									end
								end
							endcase
						end
					end
					ST_RSTA: begin
						if (st_det && !sda_drv_r) begin
							// another master's repeated start came first
							scl_drv_r <= 1'b0;
							sda_drv_r <= 1'b0;
							ev_pulse_r[`I2CER_EV_RSLOST] <= 1'b1;
							state_r <= ST_WAIT;
						end else if (tick) begin
							case (q_r)
								2'b00: begin
									sda_drv_r <= 1'b0;
									q_r <= 2'b01;
								end
								2'b01: begin
									scl_drv_r <= 1'b0;
									q_r <= 2'b10;
								end
								2'b10: begin
									if (scl_s && !sda_s) begin
										bit_r <= 4'h0;
										q_r <= 2'b00;
										state_r <= ST_UNST;
									end else if (scl_s) begin
										sda_drv_r <= 1'b1;
										q_r <= 2'b11;
									end
								end
								default: begin
									scl_drv_r <= 1'b1;
									code_r <= `I2CER_ST_RSTART;
									ctl_si_r <= 1'b1;
									addr_ph_r <= 1'b1;
									ev_pulse_r[`I2CER_EV_SI] <= 1'b1;
									state_r <= ST_HOLD;
								end
							endcase
						end
					end
					ST_ERR: begin
						// lines stay released; no stop is driven on exit
						scl_drv_r <= 1'b0;
						sda_drv_r <= 1'b0;
						if (ctl_stop_r && !ctl_si_r) begin
							ctl_stop_r <= 1'b0;
							state_r <= ST_IDLE;
						end
					end
					default: begin
						// corrupted state word recovers through the error code
						scl_drv_r <= 1'b0;
						sda_drv_r <= 1'b0;
						code_r <= `I2CER_ST_BUSERR;
						ctl_si_r <= 1'b1;
						ev_pulse_r[`I2CER_EV_BUSERR] <= 1'b1;
						ev_pulse_r[`I2CER_EV_SI] <= 1'b1;
						state_r <= ST_ERR;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// open-drain pins
	// ----------------------------------------------------------------
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = !scl_drv_r;
	assign sda_oe_n = !sda_drv_r;

endmodule // i2cer_core

// ### verif/i2cer_assertions.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// port checker for the two-wire controller
// ------------------------------------------------------------
module i2cer_chk #(
	parameter QTR_CYC = 50
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// register bus
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire irq,
	// open-drain pins
	input wire scl_i,
	input wire scl_o,
	input wire scl_oe_n,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_n
);
	reg rd_taken_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// only a read taken at the last edge may move the read data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_taken_r <= 1'b0;
		end else begin
			rd_taken_r <= hsel & htrans[1] & hready & ~hwrite;
		end
	end

	zero_wait_a: assert property (hreadyout && !hresp) else $error("bus answer late or not okay");
	upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
	rdata_hold_a: assert property (!rd_taken_r |-> $stable(hrdata)) else $error("read data moved");
	pins_low_a: assert property (!sda_o && !scl_o) else $error("open-drain pin driven high");
	reset_idle_a: assert property ($rose(hresetn) |-> sda_oe_n && scl_oe_n && !irq)
		else $error("not idle after reset");
	start_free_a: assert property ($fell(sda_oe_n) && scl_oe_n |-> $past(sda_i))
		else $error("start driven onto low data line");
	start_hold_a: assert property ($fell(sda_oe_n) && scl_oe_n |=> scl_oe_n [*3] ##[1:400] !scl_oe_n)
		else $error("start not followed by clocking");
	clock_high_a: assert property ($rose(scl_i) |-> scl_oe_n [*3])
		else $error("clock high phase cut short");
endmodule // i2cer_chk

bind i2cer_core i2cer_chk #(.QTR_CYC(QTR_CYC)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.irq(irq), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n(sda_oe_n));

// ### verif/i2cer_bus_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// other masters and slaves on the two-wire bus
// ------------------------------------------------------------
module i2cer_bus_model (
	// device enables, low pulls
	input wire scl_oe_n,
	input wire sda_oe_n,
	// wire levels
	output wire scl,
	output wire sda
);
	reg sda_hold;
	reg ack_hold;
	reg ack_en;
	reg snipe;
	integer bits;

	// pull-ups, low wins; the clock is never held here
	assign scl = scl_oe_n;
	assign sda = sda_oe_n & ~sda_hold & ~ack_hold;

	// quiet bus at time zero
	initial begin
		sda_hold = 1'b0;
		ack_hold = 1'b0;
		ack_en = 1'b0;
		snipe = 1'b0;
		bits = 0;
	end

	// a start on the wire restarts the bit count
	always @(negedge sda) begin
		if (scl) begin
			bits = 0;
		end
	end

	// slave acknowledge after the eighth bit
	always @(negedge scl) begin
		bits = (bits == 9) ? 1 : bits + 1;
		ack_hold = ack_en && (bits == 9);
	end

	// other master starts 60 ns after the clock rises
	always @(posedge scl) begin
		if (snipe && sda) begin
			#60 sda_hold = 1'b1;
			snipe = 1'b0;
		end
	end
endmodule // i2cer_bus_model

// ### verif/testbench.sv
`timescale 1ns/100ps
`include "i2cer_map.vh"

// ------------------------------------------------------------
// controller against a behavioural bus partner
// ------------------------------------------------------------
module testbench;
	// short eight-cycle quarter still keeps the start race clear of sync delay
	localparam QTR = 8;
	localparam [7:0] o_set = `I2CER_OFS_CTL_SET;
	localparam [7:0] o_clr = `I2CER_OFS_CTL_CLR;
	localparam [7:0] o_st = `I2CER_OFS_STATUS;
	localparam [7:0] o_dat = `I2CER_OFS_DATA;
	localparam [7:0] o_est = `I2CER_OFS_EVT_STAT;
	localparam [7:0] o_ecl = `I2CER_OFS_EVT_CLR;
	localparam [7:0] o_een = `I2CER_OFS_EVT_EN;
	// control bits in map order
	localparam [31:0] ack_b = 32'h04;
	localparam [31:0] flag_b = 32'h08;
	localparam [31:0] stop_b = 32'h10;
	localparam [31:0] go_b = 32'h20;
	localparam [31:0] en_b = 32'h40;
	reg hclk;
	reg hresetn;
	reg hsel;
	reg [31:0] haddr;
	reg [1:0] htrans;
	reg hwrite;
	reg [31:0] hwdata;
	wire hready;
	wire hresp;
	wire [31:0] hrdata;
	wire irq;
	wire scl;
	wire sda;
	wire scl_oe_n;
	wire sda_oe_n;
	integer fails;
	integer n_checks;
	integer k;
	integer n;
	reg [31:0] rd;
	reg p;
	reg watch;
	reg drove;

	i2cer_core #(.QTR_CYC(QTR)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq), .scl_i(scl), .scl_o(),
		.scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n));
	i2cer_bus_model bus (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

	// 20 MHz system clock
	always #25 hclk = ~hclk;

	// any device pull while it should stay off the bus
	always @(posedge hclk) begin
		if (watch && (sda_oe_n === 1'b0 || scl_oe_n === 1'b0)) drove = 1'b1;
	end

	// single word transfer, both phases wait on ready
	task ahb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge hclk);
			hsel <= 1'b1;
			htrans <= 2'b10;
			haddr <= {24'h0, a};
			hwrite <= w;
			@(posedge hclk);
			while (hready !== 1'b1) @(posedge hclk);
			hsel <= 1'b0;
			htrans <= 2'b00;
			hwdata <= d;
			@(posedge hclk);
			while (hready !== 1'b1) @(posedge hclk);
			rd = hrdata;
		end
	endtask

	// compare and count
	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	task rchk(input string what, input [7:0] a, input [31:0] exp);
		begin
			ahb(1'b0, a, 32'h0);
			chk(what, exp, rd);
		end
	endtask

	// registered irq settles two edges after a write
	task irq_is(input exp);
		begin
			repeat (2) @(posedge hclk);
			chk("irq", {31'h0, exp}, {31'h0, irq});
		end
	endtask

	// wait for the flag, compare the code, drop all events
	task serve(input [31:0] code);
		begin
			for (k = 0; k < 2000 && irq !== 1'b1; k = k + 1) @(posedge hclk);
			chk("irq", 32'h1, {31'h0, irq});
			rchk("status", o_st, code);
			// bit 0 flag, bit 1 bus error, bit 2 lost arbitration
			rchk("events", o_est, (code == 32'h00) ? 32'h3 : (code == 32'h38) ? 32'h5 : 32'h1);
			ahb(1'b1, o_ecl, 32'hf);
		end
	endtask

	task t_reset;
		begin
			rchk("status", o_st, 32'hf8);
			rchk("control", o_set, 32'h0);
			rchk("event mask", o_een, 32'h0);
			rchk("unmapped", 8'h10, 32'h0);
		end
	endtask

	// stray start leaves data low; forced access must clock it free
	task t_forced;
		begin
			ahb(1'b1, o_set, en_b);
			ahb(1'b1, o_een, 32'h1);
			bus.sda_hold = 1'b1;
			// let sync, detect and flag settle before judging
			repeat (20) @(posedge hclk);
			irq_is(1'b0);
			rchk("status", o_st, 32'hf8);
			ahb(1'b1, o_set, go_b);
			repeat (200) @(posedge hclk);
			chk("waits", 32'h1, {31'h0, sda_oe_n & scl_oe_n});
			ahb(1'b1, o_set, stop_b);
			n = 0;
			p = 1'b1;
			for (k = 0; k < 4000 && sda_oe_n !== 1'b0; k = k + 1) begin
				@(posedge hclk);
				if (p === 1'b1 && scl_oe_n === 1'b0) n = n + 1;
				if (n == 3) bus.sda_hold = 1'b0;
				p = scl_oe_n;
			end
			chk("extra clocks", 32'h4, n);
			serve(32'h08);
			rchk("control", o_set, en_b | go_b | flag_b);
		end
	endtask

	// stop inside a byte, then software recovery
	task t_buserr;
		begin
			ahb(1'b1, o_clr, go_b);
			ahb(1'b1, o_dat, 32'hff);
			ahb(1'b1, o_clr, flag_b);
			@(negedge scl);
			bus.sda_hold = 1'b1;
			@(posedge scl);
			#60 bus.sda_hold = 1'b0;
			serve(32'h00);
			chk("released", 32'h1, {31'h0, sda_oe_n & scl_oe_n});
			drove = 1'b0;
			watch = 1'b1;
			ahb(1'b1, o_set, stop_b | ack_b);
			ahb(1'b1, o_clr, flag_b);
			repeat (100) @(posedge hclk);
			watch = 1'b0;
			chk("no stop", 32'h0, {31'h0, drove});
			rchk("status", o_st, 32'hf8);
			rchk("control", o_set, en_b | ack_b);
		end
	endtask

	// lost arbitration, retry once the other master stops
	task t_arb;
		begin
			ahb(1'b1, o_set, go_b);
			serve(32'h08);
			ahb(1'b1, o_clr, go_b);
			ahb(1'b1, o_dat, 32'hff);
			bus.sda_hold = 1'b1;
			ahb(1'b1, o_clr, flag_b);
			serve(32'h38);
			ahb(1'b1, o_set, go_b);
			ahb(1'b1, o_clr, flag_b);
			repeat (100) @(posedge hclk);
			chk("waits", 32'h1, {31'h0, sda_oe_n});
			bus.sda_hold = 1'b0;
			serve(32'h08);
		end
	endtask

	// other master wins the repeated start; event mask and clear
	task t_rstart;
		begin
			ahb(1'b1, o_clr, go_b);
			ahb(1'b1, o_dat, 32'ha4);
			bus.ack_en = 1'b1;
			ahb(1'b1, o_clr, flag_b);
			serve(32'h18);
			bus.ack_en = 1'b0;
			bus.snipe = 1'b1;
			ahb(1'b1, o_set, go_b);
			ahb(1'b1, o_clr, flag_b);
			repeat (300) @(posedge hclk);
			irq_is(1'b0);
			rchk("status", o_st, 32'hf8);
			chk("released", 32'h1, {31'h0, sda_oe_n & scl_oe_n});
			rchk("events", o_est, 32'h1 << `I2CER_EV_RSLOST);
			ahb(1'b1, o_een, 32'h9);
			irq_is(1'b1);
			ahb(1'b1, o_een, 32'h1);
			irq_is(1'b0);
			ahb(1'b1, o_ecl, 32'h8);
			ahb(1'b1, o_een, 32'h9);
			irq_is(1'b0);
			bus.sda_hold = 1'b0;
			serve(32'h08);
			ahb(1'b1, o_set, stop_b);
			ahb(1'b1, o_clr, flag_b | go_b);
			repeat (200) @(posedge hclk);
			chk("stopped", 32'h1, {31'h0, sda_oe_n & scl_oe_n});
		end
	endtask

	task complete_run;
		begin
			$display("checks %0d mismatches %0d", n_checks, fails);
			if (fails == 0 && n_checks > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask

	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		fails = 0;
		n_checks = 0;
		watch = 1'b0;
		drove = 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_forced;
		t_buserr;
		t_arb;
		t_rstart;
		complete_run;
	end

	// hang guard, far beyond the hundred or so microseconds expected
	initial begin
		#2000000;
		fails = fails + 1;
		complete_run;
	end
endmodule // testbench
